/* File: sxa_defs.vh */
// Constants for the subtract/xor/swap execution datapath.
// Assumes inclusion by bare name from the datapath sources.
`ifndef SXA_DEFS_VH
`define SXA_DEFS_VH

// Operation select codes
`define SXA_OP_NONE        3'h0
`define SXA_OP_LIT_SUB     3'h1
`define SXA_OP_REG_SUB     3'h2
`define SXA_OP_XOR_IMM     3'h3
`define SXA_OP_XOR_REG     3'h4
`define SXA_OP_NIB_SWAP    3'h5

// Target select values
`define SXA_DEST_ACC       1'b0
`define SXA_DEST_REG       1'b1

// Reset values
`define SXA_ACC_RST        8'h00
`define SXA_FLAG_RST       1'b0
`define SXA_ADDR_RST       7'h00
`define SXA_DATA_RST       8'h00

// Operation latency in instruction cycles
`define SXA_OP_CYCLES      1

`endif

/* File: sxa_alu_core.v */
// Combinational result and flag logic for the five operations.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/10ps
`default_nettype none
`include "sxa_defs.vh"

module sxa_alu_core (
    // Operation
    input  wire [2:0] op,
    // Operands
    input  wire [7:0] acc,
    input  wire [7:0] imm,
    input  wire [7:0] reg_val,
    // Results
    output reg  [7:0] result,
    output reg        carry_upd,
    output reg        carry_val,
    output reg        nib_upd,
    output reg        nib_val,
    output reg        zero_upd
);

    reg [7:0] sub_src;
    reg [8:0] diff;
    reg [4:0] ndiff;

    always @* begin
        sub_src   = (op == `SXA_OP_LIT_SUB) ? imm : reg_val;
        // Ninth bit set means no borrow, i.e. acc <= operand
        diff      = {1'b0, sub_src} + {1'b0, ~acc} + 9'h001;
        ndiff     = {1'b0, sub_src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result    = 8'h00;
        carry_upd = 1'b0;
        carry_val = diff[8];
        nib_upd   = 1'b0;
        nib_val   = ndiff[4];
        zero_upd  = 1'b0;
        case (op)
            `SXA_OP_LIT_SUB, `SXA_OP_REG_SUB: begin
                result    = diff[7:0];
                carry_upd = 1'b1;
                nib_upd   = 1'b1;
                zero_upd  = 1'b1;
            end
            `SXA_OP_XOR_IMM: begin
                result   = acc ^ imm;
                zero_upd = 1'b1;
            end
            `SXA_OP_XOR_REG: begin
                result   = acc ^ reg_val;
                zero_upd = 1'b1;
            end
            `SXA_OP_NIB_SWAP: begin
                result = {reg_val[3:0], reg_val[7:4]};
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

endmodule // sxa_alu_core

`default_nettype wire

/* File: sxa_datapath.v */
// Execution datapath: subtract, xor and nibble swap with write-back.
// Assumes one request per instruction cycle; register file lives outside.
// What this block does
// - Immediate minus accumulator, two's complement, result into accumulator.
// - Subtracts set borrow-inverse when acc <= operand and nibble flag when acc[3:0] <= operand[3:0]; zero updated.
// - Register minus accumulator; target select picks accumulator or register.
// - Accumulator xor immediate into accumulator; only zero flag changes.
// - Accumulator xor register to chosen target; only zero flag changes.
// - Swap register nibbles to chosen target; no flag changes.
`timescale 1ns/10ps
`default_nettype none
`include "sxa_defs.vh"

module sxa_datapath (
    // Clock and reset
    input  wire       clock,
    input  wire       rst,
    // Request
    input  wire       op_valid,
    input  wire [2:0] op,
    input  wire       dest_sel,
    input  wire [7:0] imm,
    input  wire [6:0] reg_addr,
    input  wire [7:0] reg_val,
    // Accumulator and flags
    output reg  [7:0] acc_r,
    output reg        carry_r,
    output reg        nibble_borrow_inverse_flag_r,
    output reg        zero_r,
    // Register write-back
    output reg        reg_we_r,
    output reg  [6:0] reg_waddr_r,
    output reg  [7:0] reg_wdata_r,
    // Completion
    output reg        done_r
);

    // Decoded request
    reg  [2:0] op_eff;
    wire       known;
    wire       to_reg;
    wire       to_acc;

    // Results and flag strobes from the operation core
    wire [7:0] result;
    wire       carry_upd;
    wire       carry_val;
    wire       nib_upd;
    wire       nib_val;
    wire       zero_upd;

    // Zero detect chain, one stage per result bit
    wire [8:0] any_one;
    wire       result_zero;
    genvar     gi;

    // Next values of the output registers
    reg  [7:0] acc_nxt;
    reg        carry_nxt;
    reg        nib_flag_nxt;
    reg        zero_nxt;
    reg        reg_we_nxt;
    reg  [6:0] reg_waddr_nxt;
    reg  [7:0] reg_wdata_nxt;
    reg        done_nxt;

    // Codes 0, 6 and 7 are refused and behave as a no-operation
    function op_legal;
        input [2:0] o;
        begin
            case (o)
                `SXA_OP_LIT_SUB,
                `SXA_OP_REG_SUB,
                `SXA_OP_XOR_IMM,
                `SXA_OP_XOR_REG,
                `SXA_OP_NIB_SWAP: op_legal = 1'b1;
                default:          op_legal = 1'b0;
            endcase
        end
    endfunction

    // Register-sourced ops honour target select; immediate ops always go to acc
    function uses_dest;
        input [2:0] o;
        begin
            case (o)
                `SXA_OP_REG_SUB,
                `SXA_OP_XOR_REG,
                `SXA_OP_NIB_SWAP: uses_dest = 1'b1;
                default:          uses_dest = 1'b0;
            endcase
        end
    endfunction

    // Refused requests collapse to the no-operation code before the core
    // Op and target come straight from the pins; they must hold all cycle
    always @* begin
        if (op_valid && op_legal(op)) begin
            op_eff = op;
        end else begin
            op_eff = `SXA_OP_NONE;
        end
    end

    assign known  = op_legal(op_eff);
    assign to_reg = known && uses_dest(op_eff) && (dest_sel == `SXA_DEST_REG);
    assign to_acc = known && !to_reg;

    // The core sees the registered accumulator, so each op uses the
    // result of the op before it with no forwarding path to get wrong
    sxa_alu_core u_sxa_alu_core (
        .op        (op_eff),
        .acc       (acc_r),
        .imm       (imm),
        .reg_val   (reg_val),
        .result    (result),
        .carry_upd (carry_upd),
        .carry_val (carry_val),
        .nib_upd   (nib_upd),
        .nib_val   (nib_val),
        .zero_upd  (zero_upd)
    );

    // Zero flag from an OR chain over the result bits
    // Chain depth is eight gates, well inside one 25 ns cycle
    assign any_one[0] = 1'b0;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_zero
            assign any_one[gi+1] = any_one[gi] | result[gi];
        end
    endgenerate
    assign result_zero = ~any_one[8];

    // Accumulator takes immediate ops and target select 0
    always @* begin
        acc_nxt = acc_r;
        if (to_acc) begin
            acc_nxt = result;
        end
    end

    // Each flag moves only when the core marks it as touched
    // Swap marks no flag, so status survives it untouched
    always @* begin
        carry_nxt    = carry_r;
        nib_flag_nxt = nibble_borrow_inverse_flag_r;
        zero_nxt     = zero_r;
        if (carry_upd) begin
            carry_nxt = carry_val;
        end
        if (nib_upd) begin
            nib_flag_nxt = nib_val;
        end
        if (zero_upd) begin
            zero_nxt = result_zero;
        end
    end

    // Address and data hold between writes so the outside can latch late
    // Write enable is a pulse; address and data only mean something with it
    always @* begin
        reg_we_nxt    = to_reg;
        reg_waddr_nxt = reg_waddr_r;
        reg_wdata_nxt = reg_wdata_r;
        if (to_reg) begin
            reg_waddr_nxt = reg_addr;
            reg_wdata_nxt = result;
        end
    end

    // One completion pulse per accepted op; there is no busy state
    always @* begin
        done_nxt = known;
    end

    // Accumulator register
    always @(posedge clock) begin
        if (rst) begin
            acc_r <= `SXA_ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Status flags
    always @(posedge clock) begin
        if (rst) begin
            carry_r                      <= `SXA_FLAG_RST;
            nibble_borrow_inverse_flag_r <= `SXA_FLAG_RST;
            zero_r                       <= `SXA_FLAG_RST;
        end else begin
            carry_r                      <= carry_nxt;
            nibble_borrow_inverse_flag_r <= nib_flag_nxt;
            zero_r                       <= zero_nxt;
        end
    end

    // Register write-back port
    always @(posedge clock) begin
        if (rst) begin
            reg_we_r    <= 1'b0;
            reg_waddr_r <= `SXA_ADDR_RST;
            reg_wdata_r <= `SXA_DATA_RST;
        end else begin
            reg_we_r    <= reg_we_nxt;
            reg_waddr_r <= reg_waddr_nxt;
            reg_wdata_r <= reg_wdata_nxt;
        end
    end

    // Completion strobe; back-to-back requests need no gap
    always @(posedge clock) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

endmodule // sxa_datapath

`default_nettype wire

/* File: sxa_chk_sva.sv */
// Port checker for the subtract/xor/swap datapath.
// Bound onto the datapath from the bench top.
`timescale 1ns/10ps
`default_nettype none
module sxa_chk (
    // Grouped to keep the checker short
    input wire logic       clock, rst, op_valid, dest_sel, reg_we_r, done_r,
    input wire logic       carry_r, nibble_borrow_inverse_flag_r, zero_r,
    input wire logic [2:0] op,
    input wire logic [7:0] imm, reg_val, acc_r, reg_wdata_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire       go = op_valid && op != 3'h0 && op < 3'h6;
    wire [7:0] b  = (op == 3'h1 || op == 3'h3) ? imm : reg_val;
    wire [7:0] d  = b - acc_r;
    wire [7:0] x  = acc_r ^ b;
    wire [7:0] s  = {reg_val[3:0], reg_val[7:4]};
    wire [1:0] le = {acc_r <= b, acc_r[3:0] <= b[3:0]};
    wire [1:0] nf = {carry_r, nibble_borrow_inverse_flag_r};
    lit_sub_a: assert property (go && op == 3'h1 |=> acc_r == $past(d))
        else $error("lit sub");
    sub_flags_a: assert property (go && op < 3'h3 |=> nf == $past(le))
        else $error("sub flags");
    reg_sub_a: assert property (go && op == 3'h2 && dest_sel |=> reg_wdata_r == $past(d))
        else $error("reg sub");
    xor_imm_a: assert property (go && op == 3'h3 |=> acc_r == $past(x) && nf == $past(nf))
        else $error("xor imm");
    xor_reg_a: assert property (go && op == 3'h4 |=> zero_r == ($past(x) == 8'h00))
        else $error("xor reg");
    nib_swap_a: assert property (go && op == 3'h5 && !dest_sel |=> acc_r == $past(s))
        else $error("swap");
    one_cycle_a: assert property (1'b1 |=> done_r == $past(go))
        else $error("done");
    cover property (go && op == 3'h2 && dest_sel);
    cover property (done_r && reg_we_r);
    cover property (go ##1 go);
endmodule // sxa_chk
`default_nettype wire

/* File: tb_subtract_xor_swap_alu_ops.sv */
// Random bench for the subtract/xor/swap datapath.
// Assumes the datapath and its checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module tb_subtract_xor_swap_alu_ops;
    logic        clock = 0, rst = 1, op_valid = 0, dest_sel = 0, m_c = 0, m_nb = 0, m_z = 0;
    logic [2:0]  op = 0;
    logic [7:0]  imm = 0, reg_val = 0, acc_r, reg_wdata_r, m_acc = 0, m_wd = 0;
    logic [6:0]  reg_addr = 0, reg_waddr_r, m_wa = 0;
    logic        carry_r, nibble_borrow_inverse_flag_r, zero_r, reg_we_r, done_r;
    logic [27:0] q[$];
    int          n_mismatch = 0, n_tests = 0;
    wire  [27:0] got = {done_r, acc_r, carry_r, nibble_borrow_inverse_flag_r, zero_r,
                        reg_we_r, reg_waddr_r, reg_wdata_r};
    sxa_datapath u_sxa_datapath (.*);
    initial forever #12.5 clock = ~clock;
    task chk(input [27:0] e, input [27:0] g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Model runs before driving; result is due one edge later
    task step(input v, input [2:0] o, input d, input [7:0] k, input [7:0] f, input [6:0] a);
        logic [7:0] b, r;
        logic       g, w;
        b = (o == 3'h1 || o == 3'h3) ? k : f;
        r = (o == 3'h5) ? {f[3:0], f[7:4]} : (o < 3'h3) ? b - m_acc : m_acc ^ b;
        g = v && o != 3'h0 && o < 3'h6;
        w = g && d && (o == 3'h2 || o == 3'h4 || o == 3'h5);
        if (g) begin
            if (o < 3'h3) {m_c, m_nb} = {m_acc <= b, m_acc[3:0] <= b[3:0]};
            if (o != 3'h5) m_z = (r == 8'h00);
            if (w) {m_wa, m_wd} = {a, r};
            else m_acc = r;
        end
        // Refused steps are noted too, so a stray state change is caught
        q.push_back({g, m_acc, m_c, m_nb, m_z, w, m_wa, m_wd});
        {op_valid, op, dest_sel, imm, reg_val, reg_addr} = {v, o, d, k, f, a};
        @(posedge clock) #2;
    endtask
    always @(posedge clock) begin
        #1;
        if (!rst && (done_r !== 1'b0 || q.size() > 0))
            chk(q.size() ? q.pop_front() : 28'h000_0000, got);
    end
    initial begin
        void'($urandom(87));
        repeat (2) @(posedge clock);
        #2 rst = 0;
        chk(28'h000_0000, got);
        for (int o = 1; o < 6; o++) begin
            step(1'b1, 3'(o), 1'b1, 8'hff, 8'hff, 7'h7f);
            step(1'b1, 3'(o), 1'b0, 8'h00, 8'h00, 7'h00);
        end
        // Mid-run reset must clear every output at once
        rst = 1;
        @(posedge clock) #2;
        rst = 0;
        {m_acc, m_c, m_nb, m_z, m_wa, m_wd} = 26'h000_0000;
        chk(28'h000_0000, got);
        for (int i = 0; i < 500; i++)
            step($urandom % 8 != 0, 3'($urandom), 1'($urandom), 8'($urandom), 8'($urandom),
                 7'($urandom));
        step(1'b0, 3'h0, 1'b0, 8'h00, 8'h00, 7'h00);
        chk(28'(q.size()), 28'h000_0000);
        close_out();
    end
endmodule // tb_subtract_xor_swap_alu_ops
bind sxa_datapath sxa_chk u_sxa_chk (.*);
`default_nettype wire
